// File: core/fims_top.sv
// Interrupt flags, mask and write-strobe commands of the voice framer
`timescale 1ns/1ns
`default_nettype none
`include "fims_defs.svh"
// ---------------------------------------------
// Function
// - Lock-loss flag is 1 while synthesizer unlocked, 0 while locked.
// - Receive fault ORs lost-sync entry, elastic errors, counter overflows.
// - Receive-frame flag sets at each received 6 ms frame start.
// - Transmit fault sets on frame reposition or elastic under/overflow.
// - Transmit-frame flag sets at each transmitted 6 ms frame start.
// - Mask has one read/write bit per flag; 1 masks, 0 unmasks.
// - Request line low whenever any set flag is unmasked.
// - Hardware reset forces every mask bit to 1.
// - Scrambler command loads 23-stage register with 0x000001.
// - Up to three transmit store errors may follow a flush.
// - Pointer-clear writes reset the transmit or receive signaling pointers.
// - Receive flush empties store and realigns payload mapper.
// - Resync write forces lost-sync, restarts search, sets receive fault.
// - Error-clear write clears both counters and overflow bits now.
// - Realign write reloads watermark; aligned timebase stays unchanged.
// - With auto enable, realign runs itself on in-sync realignment.
// - Copy writes move signaling input store into output store.
// - Read-signaling flag every 6/3/2/1 ms, always with receive frame.
// - Signaling store fault flag sets on any signaling over/underflow.
// ---------------------------------------------
module fims_top #(
  parameter int MS_CYCLES = `FIMS_MS_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Host register port, strobes active low
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  output logic [7:0] o_rdata,
  output logic o_irq_n,
  // Synthesizer lock status, asynchronous level
  input wire logic i_lock_loss,
  // Receive events from the datapath, one-cycle pulses
  input wire logic i_rx_lost_sync,
  input wire logic i_rx_elastic_err,
  input wire logic i_checksum_ovf,
  input wire logic i_far_block_ovf,
  input wire logic i_rx_frame_start,
  input wire logic i_rx_realigned_insync,
  // Transmit events from the datapath, one-cycle pulses
  input wire logic i_tx_frame_start,
  input wire logic i_tx_reposition,
  input wire logic i_tx_elastic_err,
  // Signaling store over/underflow, one-cycle pulse
  input wire logic i_signaling_fifo_fault_flag,
  // Configuration levels
  input wire logic i_auto_realign_enable,
  input wire fims_pkg::fims_rate_t i_signaling_rate_select,
  // Command pulses and scrambler seed to the datapath
  output fims_pkg::fims_cmd_t o_cmd,
  output logic [`FIMS_SCR_W-1:0] o_scr_seed
);
  // ---------------------------------------------
  // Reset release
  // ---------------------------------------------
  logic [1:0] rst_pipe;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ---------------------------------------------
  // Pin synchronisation and strobe edges
  // ---------------------------------------------
  logic wr_n_s;
  logic rd_n_s;
  logic lock_s;
  logic [7:0] addr_s;
  logic [7:0] wdata_s;
  logic wr_n_q;
  logic rd_n_q;
  logic wr_evt;
  logic rd_evt;

  fims_sync #(
    .W(19),
    .RST_VAL(`FIMS_PIN_RST)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_d({i_wr_n, i_rd_n, i_lock_loss, i_addr, i_wdata}),
    .o_q({wr_n_s, rd_n_s, lock_s, addr_s, wdata_s})
  );

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
    end else begin
      wr_n_q <= wr_n_s;
      rd_n_q <= rd_n_s;
    end
  end

  // One event per falling strobe, however long the strobe is held
  assign wr_evt = wr_n_q & ~wr_n_s;
  assign rd_evt = rd_n_q & ~rd_n_s;

  // ---------------------------------------------
  // Command decode
  // ---------------------------------------------
  fims_pkg::fims_cmd_t next_cmd;

  always_comb begin
    next_cmd = '0;
    if (wr_evt) begin
      // Written data is ignored by every command
      case (addr_s)
        `FIMS_ADDR_SCR: next_cmd.scrambler_reload = 1'b1;
        `FIMS_ADDR_TX_FLUSH: next_cmd.tx_flush = 1'b1;
        `FIMS_ADDR_TX_SIG_PTR: next_cmd.tx_sig_ptr_clear = 1'b1;
        `FIMS_ADDR_RX_SIG_PTR: next_cmd.rx_sig_ptr_clear = 1'b1;
        `FIMS_ADDR_RX_FLUSH: next_cmd.rx_flush = 1'b1;
        `FIMS_ADDR_RESYNC: next_cmd.framer_resync = 1'b1;
        `FIMS_ADDR_ERR_CLR: next_cmd.err_counter_clear = 1'b1;
        `FIMS_ADDR_REALIGN: next_cmd.rx_realign = 1'b1;
        `FIMS_ADDR_TX_SIG_COPY: next_cmd.tx_sig_copy = 1'b1;
        `FIMS_ADDR_RX_SIG_COPY: next_cmd.rx_sig_copy = 1'b1;
        default: next_cmd = '0;
      endcase
    end
    // Datapath skips the reload when already aligned
    if (i_auto_realign_enable && i_rx_realigned_insync) begin
      next_cmd.rx_realign = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_cmd <= '0;
    end else begin
      o_cmd <= next_cmd;
    end
  end

  // Seed held constant; the datapath loads it on the reload pulse
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_scr_seed <= `FIMS_SCR_SEED;
    end else begin
      o_scr_seed <= `FIMS_SCR_SEED;
    end
  end

  // ---------------------------------------------
  // Signaling update ticks
  // ---------------------------------------------
  logic rsig_tick;
  logic tsig_tick;

  fims_sig_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_rx_sig_timer (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_frame(i_rx_frame_start),
    .i_rate(i_signaling_rate_select),
    .o_tick(rsig_tick)
  );

  fims_sig_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tx_sig_timer (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_frame(i_tx_frame_start),
    .i_rate(i_signaling_rate_select),
    .o_tick(tsig_tick)
  );

  // ---------------------------------------------
  // Interrupt flags
  // ---------------------------------------------
  fims_pkg::fims_flags_t flags;
  fims_pkg::fims_flags_t set_ev;
  fims_pkg::fims_flags_t rd_clr;

  always_comb begin
    set_ev = '0;
    set_ev.rx_fault = i_rx_lost_sync | i_rx_elastic_err
      | i_checksum_ovf | i_far_block_ovf
      | next_cmd.framer_resync;
    set_ev.rx_frame = i_rx_frame_start;
    set_ev.read_signaling = rsig_tick;
    // Errors right after a flush are reported like any other
    set_ev.tx_fault = i_tx_reposition | i_tx_elastic_err;
    set_ev.tx_frame = i_tx_frame_start;
    set_ev.load_signaling = tsig_tick;
    set_ev.sig_fifo_fault = i_signaling_fifo_fault_flag;
  end

  // A read of the flag register clears what it returned except the lock-loss bit, which follows the lock level
  assign rd_clr = (rd_evt && addr_s == `FIMS_ADDR_FLAGS) ? flags : '0;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= `FIMS_FLAGS_RST;
    end else begin
      // Set beats clear in the same cycle
      flags <= (flags & ~rd_clr) | set_ev;
      flags.lock_loss <= lock_s;
    end
  end

  // ---------------------------------------------
  // Mask and request line
  // ---------------------------------------------
  logic [7:0] mask;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= `FIMS_MASK_RST;
    end else if (wr_evt && addr_s == `FIMS_ADDR_MASK) begin
      mask <= wdata_s;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_irq_n <= 1'b1;
    end else begin
      o_irq_n <= ~|(flags & ~mask);
    end
  end

  // ---------------------------------------------
  // Read data
  // ---------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= `FIMS_RDATA_RST;
    end else if (rd_evt) begin
      case (addr_s)
        `FIMS_ADDR_FLAGS: o_rdata <= flags;
        `FIMS_ADDR_MASK: o_rdata <= mask;
        // Command registers read as zero and do nothing
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n);

  chk_lock_flag_level: assert property (
    i_lock_loss [*4] |-> flags.lock_loss)
    else $error("lock-loss flag low while unlocked");

  chk_rx_fault_set: assert property (
    (i_rx_lost_sync || i_rx_elastic_err || i_checksum_ovf ||
     i_far_block_ovf) |=> flags.rx_fault)
    else $error("receive fault event lost");

  chk_rx_frame_pair: assert property (
    i_rx_frame_start |=> flags.rx_frame && flags.read_signaling)
    else $error("receive frame without read-signaling flag");

  chk_tx_fault_set: assert property (
    (i_tx_reposition || i_tx_elastic_err) |=> flags.tx_fault)
    else $error("transmit fault event lost");

  chk_tx_frame_set: assert property (
    i_tx_frame_start |=> flags.tx_frame && flags.load_signaling)
    else $error("transmit frame flag not set");

  chk_mask_write: assert property (
    (wr_evt && addr_s == `FIMS_ADDR_MASK) |=> mask == $past(wdata_s))
    else $error("mask write not stored");

  chk_irq_gate: assert property (
    (|(flags & ~mask)) [*2] |-> !o_irq_n)
    else $error("unmasked flag without request");

  chk_irq_idle: assert property (
    (flags & ~mask) == 8'h00 |=> o_irq_n)
    else $error("request with no unmasked flag");

  chk_mask_reset: assert property (
    $rose(rst_n) |-> mask == `FIMS_MASK_RST && o_irq_n)
    else $error("mask not all ones after reset");

  chk_resync_fault: assert property (
    (wr_evt && addr_s == `FIMS_ADDR_RESYNC) |=>
      o_cmd.framer_resync && flags.rx_fault)
    else $error("resync without receive fault");

  chk_auto_realign: assert property (
    (i_auto_realign_enable && i_rx_realigned_insync) |=> o_cmd.rx_realign)
    else $error("automatic realign missing");

  chk_scr_seed: assert property (
    o_cmd.scrambler_reload |-> o_scr_seed == `FIMS_SCR_SEED)
    else $error("scrambler seed wrong");

  chk_cmd_pulse: assert property (
    (wr_evt && addr_s == `FIMS_ADDR_ERR_CLR) |=>
      o_cmd.err_counter_clear ##1 !o_cmd.err_counter_clear)
    else $error("error clear not a single pulse");

  chk_read_quiet: assert property (
    (rd_evt && !i_rx_realigned_insync) |=> o_cmd == '0)
    else $error("read produced a command");

  chk_sig_fault_set: assert property (
    i_signaling_fifo_fault_flag |=> flags.sig_fifo_fault)
    else $error("signaling fault event lost");

  chk_sig_tick_flag: assert property (
    rsig_tick |=> flags.read_signaling)
    else $error("signaling tick without flag");

  chk_ptr_clear_decode: assert property (
    (wr_evt && addr_s == `FIMS_ADDR_RX_SIG_PTR) |=> o_cmd.rx_sig_ptr_clear)
    else $error("pointer clear pulse missing");

  chk_copy_decode: assert property (
    (wr_evt && addr_s == `FIMS_ADDR_TX_SIG_COPY) |=> o_cmd.tx_sig_copy)
    else $error("signaling copy pulse missing");

  cov_irq_raised: cover property ($fell(o_irq_n));
  cov_resync: cover property (o_cmd.framer_resync);
  cov_sub_tick: cover property (rsig_tick && !i_rx_frame_start);
  cov_flag_read: cover property (rd_evt && addr_s == `FIMS_ADDR_FLAGS);
endmodule
`default_nettype wire

// File: core/fims_defs.svh
// Offsets, reset values and timing counts of the interrupt/strobe block
`ifndef FIMS_DEFS_SVH
`define FIMS_DEFS_SVH
// ---------------------------------------------
// Register offsets
// ---------------------------------------------
`define FIMS_ADDR_FLAGS 8'hD0
`define FIMS_ADDR_MASK 8'hD1
`define FIMS_ADDR_SCR 8'hD3
`define FIMS_ADDR_TX_FLUSH 8'hD4
`define FIMS_ADDR_TX_SIG_PTR 8'hD5
`define FIMS_ADDR_RX_SIG_PTR 8'hD6
`define FIMS_ADDR_RX_FLUSH 8'hD7
`define FIMS_ADDR_RESYNC 8'hD8
`define FIMS_ADDR_ERR_CLR 8'hD9
`define FIMS_ADDR_REALIGN 8'hDA
`define FIMS_ADDR_TX_SIG_COPY 8'hDB
`define FIMS_ADDR_RX_SIG_COPY 8'hDC
// ---------------------------------------------
// Reset values and fields
// ---------------------------------------------
`define FIMS_MASK_RST 8'hFF
`define FIMS_FLAGS_RST 8'h00
`define FIMS_RDATA_RST 8'h00
`define FIMS_PIN_RST 19'h60000
`define FIMS_SCR_W 23
`define FIMS_SCR_SEED 23'h000001
// ---------------------------------------------
// Timing
// ---------------------------------------------
`define FIMS_CLK_NS 100
`define FIMS_MS_NS 1000000
`define FIMS_MS_CYC (`FIMS_MS_NS / `FIMS_CLK_NS)
`define FIMS_FRAME_MS 6
`endif

// File: core/fims_pkg.sv
// Types shared by the interrupt/strobe block
package fims_pkg;
  typedef struct packed {
    logic sig_fifo_fault;
    logic read_signaling;
    logic load_signaling;
    logic lock_loss;
    logic rx_fault;
    logic rx_frame;
    logic tx_fault;
    logic tx_frame;
  } fims_flags_t;

  typedef struct packed {
    logic scrambler_reload;
    logic tx_flush;
    logic tx_sig_ptr_clear;
    logic rx_sig_ptr_clear;
    logic rx_flush;
    logic framer_resync;
    logic err_counter_clear;
    logic rx_realign;
    logic tx_sig_copy;
    logic rx_sig_copy;
  } fims_cmd_t;

  typedef enum logic [1:0] {
    RATE_6MS,
    RATE_3MS,
    RATE_2MS,
    RATE_1MS
  } fims_rate_t;
endpackage

// File: core/fims_sync.sv
// Two-flop synchroniser for pins entering the system clock
`timescale 1ns/1ns
`default_nettype none
module fims_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pin side and clock side
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= RST_VAL;
      o_q <= RST_VAL;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule
`default_nettype wire

// File: core/fims_sig_timer.sv
// Signaling update tick: frame start plus evenly spaced extra ticks
`timescale 1ns/1ns
`default_nettype none
`include "fims_defs.svh"
module fims_sig_timer #(
  parameter int MS_CYCLES = `FIMS_MS_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Frame start and rate
  input wire logic i_frame,
  input wire fims_pkg::fims_rate_t i_rate,
  // Update tick, same cycle as frame start
  output logic o_tick
);
  logic [31:0] cnt;
  logic [2:0] sub;
  logic hit;

  function automatic logic [2:0] extra(input fims_pkg::fims_rate_t r);
    case (r)
      fims_pkg::RATE_3MS: extra = 3'h1;
      fims_pkg::RATE_2MS: extra = 3'h2;
      fims_pkg::RATE_1MS: extra = 3'h5;
      default: extra = 3'h0;
    endcase
  endfunction

  function automatic logic [31:0] span(input fims_pkg::fims_rate_t r);
    span = 32'(`FIMS_FRAME_MS / (32'(extra(r)) + 1) * MS_CYCLES);
  endfunction

  // Extra ticks stop once the frame's share is used, so a late frame
  // start never produces a doubled tick
  assign hit = (sub < extra(i_rate)) && (cnt == span(i_rate) - 32'h1);
  assign o_tick = i_frame | hit;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 32'h0;
      sub <= 3'h0;
    end else if (i_frame) begin
      cnt <= 32'h0;
      sub <= 3'h0;
    end else if (hit) begin
      cnt <= 32'h0;
      sub <= sub + 3'h1;
    end else if (sub < extra(i_rate)) begin
      cnt <= cnt + 32'h1;
    end
  end
endmodule
`default_nettype wire

// File: dv/fims_tb.sv
// Self-checking bench for the interrupt flag, mask and strobe block
`timescale 1ns/1ns
`default_nettype none
module fims_tb;
  // ---------------------------------------------
  // Stimulus, outputs and model state
  // ---------------------------------------------
  // Short millisecond keeps the signaling ticks within a brief run
  localparam int MS = 20;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr_n = 1'b1;
  logic i_rd_n = 1'b1;
  logic i_lock_loss = 1'b0;
  logic [9:0] ev = 10'h000;
  logic i_auto_realign_enable = 1'b0;
  fims_pkg::fims_rate_t rate = fims_pkg::RATE_6MS;
  wire logic [7:0] o_rdata;
  wire logic o_irq_n;
  wire fims_pkg::fims_cmd_t o_cmd;
  wire logic [22:0] o_scr_seed;
  logic [7:0] flags = 8'h00;
  logic [7:0] mask = 8'hFF;
  logic [7:0] q = 8'h00;
  int miscompares = 0;
  int checks = 0;
  int seed = 38359;
  int cyc = 0;
  int t0 = 0;

  fims_top #(.MS_CYCLES(MS)) DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr_n(i_wr_n), .i_rd_n(i_rd_n),
    .o_rdata(o_rdata), .o_irq_n(o_irq_n), .i_lock_loss(i_lock_loss),
    .i_rx_lost_sync(ev[0]), .i_rx_elastic_err(ev[1]),
    .i_checksum_ovf(ev[2]), .i_far_block_ovf(ev[3]),
    .i_rx_frame_start(ev[4]), .i_tx_frame_start(ev[5]),
    .i_tx_reposition(ev[6]), .i_tx_elastic_err(ev[7]),
    .i_signaling_fifo_fault_flag(ev[8]), .i_rx_realigned_insync(ev[9]),
    .i_auto_realign_enable(i_auto_realign_enable),
    .i_signaling_rate_select(rate), .o_cmd(o_cmd),
    .o_scr_seed(o_scr_seed));

  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  task automatic results();
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Flag bits raised by each event input
  function automatic logic [7:0] fbit(input int i);
    case (i)
      0, 1, 2, 3: fbit = 8'h08;
      4: fbit = 8'h44;
      5: fbit = 8'h21;
      6, 7: fbit = 8'h02;
      8: fbit = 8'h80;
      default: fbit = 8'h00;
    endcase
  endfunction

  task automatic pulse(input logic [9:0] v);
    ev = v;
    for (int j = 0; j < 10; j++) begin
      if (v[j]) flags = flags | fbit(j);
    end
    @(negedge i_clk);
    ev = 10'h000;
  endtask

  // Counts command pulses over seven cycles; also ends a bus strobe
  task automatic watch(input logic [9:0] e);
    int hit;
    int bad;
    hit = 0;
    bad = 0;
    for (int k = 1; k <= 7; k++) begin
      @(negedge i_clk);
      if (e != 10'h000 && o_cmd === e) hit++;
      else if (o_cmd !== 10'h000) bad++;
      if (k == 4) begin
        q = o_rdata;
        i_wr_n = 1'b1;
        i_rd_n = 1'b1;
      end
    end
    chk("cmd pulses", {31'd0, e != 10'h000}, hit);
    chk("stray cmd", 0, bad);
  endtask

  task automatic acc(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    logic [9:0] e;
    logic [7:0] lk;
    e = 10'h000;
    if (wr && a >= 8'hD3 && a <= 8'hDC) e = 10'h200 >> (a - 8'hD3);
    i_addr = a;
    i_wdata = d;
    @(negedge i_clk);
    if (wr) i_wr_n = 1'b0;
    else i_rd_n = 1'b0;
    watch(e);
    lk = {3'b000, i_lock_loss, 4'b0000};
    if (!wr) chk("rdata", a == 8'hD0 ? (flags | lk) :
                 a == 8'hD1 ? mask : 8'h00, q);
    if (!wr && a == 8'hD0) flags = 8'h00;
    if (wr && a == 8'hD1) mask = d;
    if (wr && a == 8'hD8) flags[3] = 1'b1;
    chk("irq", ~|((flags | lk) & ~mask), o_irq_n);
  endtask

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  initial begin
    repeat (6) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clk);
    acc(0, 8'hD1, 8'h00);
    acc(0, 8'hD0, 8'h00);
    chk("seed", 23'h000001, o_scr_seed);
    for (int a = 8'hD3; a <= 8'hDC; a++) begin
      acc(1, a[7:0], 8'($random(seed)));
      acc(0, a[7:0], 8'h00);
      if (a == 8'hD8) acc(0, 8'hD0, 8'h00);
    end
    acc(1, 8'hD0, 8'hFF);
    acc(1, 8'hD2, 8'h00);
    acc(0, 8'hD2, 8'h00);
    acc(0, 8'hD0, 8'h00);
    for (int i = 0; i < 10; i++) begin
      pulse(10'h001 << i);
      acc(0, 8'hD0, 8'h00);
    end
    // Host recovery writes right after the events that call for them
    pulse(10'h080);
    acc(1, 8'hD4, 8'h00);
    pulse(10'h080);
    acc(0, 8'hD0, 8'h00);
    pulse(10'h002);
    acc(1, 8'hD7, 8'h00);
    acc(1, 8'hD8, 8'h00);
    pulse(10'h010);
    acc(1, 8'hD9, 8'h00);
    acc(1, 8'hDA, 8'h00);
    acc(0, 8'hD0, 8'h00);
    i_lock_loss = 1'b1;
    repeat (4) @(negedge i_clk);
    acc(0, 8'hD0, 8'h00);
    acc(0, 8'hD0, 8'h00);
    i_lock_loss = 1'b0;
    repeat (4) @(negedge i_clk);
    acc(0, 8'hD0, 8'h00);
    pulse(10'h120);
    acc(1, 8'hD1, 8'hFE);
    acc(1, 8'hD1, 8'hFF);
    for (int n = 0; n < 8; n++) begin
      acc(1, 8'hD1, n[0] ? 8'hFF : 8'($random(seed)));
      acc(0, 8'hD1, 8'h00);
    end
    acc(0, 8'hD0, 8'h00);
    for (int r = 0; r < 4; r++) begin
      rate = fims_pkg::fims_rate_t'(r);
      repeat (2) @(negedge i_clk);
      t0 = cyc;
      pulse(10'h030);
      acc(0, 8'hD0, 8'h00);
      while (cyc < t0 + MS * (6 / (r + 1)) + 10) @(negedge i_clk);
      if (r > 0) flags = flags | 8'h60;
      acc(0, 8'hD0, 8'h00);
      while (cyc < t0 + 7 * MS) @(negedge i_clk);
      if (r >= 2) flags = flags | 8'h60;
      acc(0, 8'hD0, 8'h00);
    end
    for (int en = 0; en < 2; en++) begin
      i_auto_realign_enable = en[0];
      // Command stands only until the next edge, so look at once
      ev = 10'h200;
      @(negedge i_clk);
      ev = 10'h000;
      chk("auto realign", en[0] ? 10'h004 : 10'h000, o_cmd);
      watch(10'h000);
    end
    // Reset in mid-run with an unmasked flag pending
    acc(1, 8'hD1, 8'h00);
    pulse(10'h100);
    repeat (3) @(negedge i_clk);
    chk("irq", 1'b0, o_irq_n);
    i_rst_n = 1'b0;
    mask = 8'hFF;
    flags = 8'h00;
    repeat (3) @(negedge i_clk);
    chk("irq", 1'b1, o_irq_n);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clk);
    acc(0, 8'hD1, 8'h00);
    results();
  end

  // Run needs about 1200 cycles; allow about eight times that
  initial begin
    #1000000;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
